// ==== ssmp_guard.sv ====
// access filter: decides whether a word may be read or written
`timescale 1ns/1ps
module ssmp_guard (
  input wire logic [1:0] bank,
  input wire logic [13:0] addr,
  input wire logic killed,
  input wire logic key_set,
  input wire logic [7:0] area_guard,
  input wire logic [7:0] area_lock,
  input wire logic bank_lock,
  input wire logic past_end,
  output logic rd_ok,
  output logic wr_ok,
  output logic wr_locked
);
  // user area index from address bits 11:9
  wire [2:0] area = addr[11:9];
  wire in_user = (bank == ssmp_pkg::BANK_USER) &&
                 (addr <= ssmp_pkg::ADDR_USER_TOP);
  wire guarded = in_user && area_guard[area];
  wire locked = (in_user && area_lock[area]) || bank_lock;
  // a guarded or keyed or killed word reads as zero
  assign rd_ok = !killed && !key_set && !guarded && !past_end &&
                 (bank != ssmp_pkg::BANK_A);
  assign wr_ok = !killed && !key_set && !guarded && !locked &&
                 !past_end && in_user;
  assign wr_locked = !killed && !wr_ok;
endmodule : ssmp_guard

// ==== ssmp_host.sv ====
// host controller model that frames commands on the serial link
`timescale 1ns/1ps
module ssmp_host (
  input wire logic clk,
  output logic select_n,
  output logic link_clk,
  output logic serial_in,
  input wire logic line
);
  // clk cycles per link half period, 80 ns at 5 ns
  localparam int HALF = 16;
  // idle: deselected, link clock parked low between frames
  initial begin
    select_n = 1'b1;
    link_clk = 1'b0;
    serial_in = 1'b0;
  end
  // pass system clocks, moving only on falling edges
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  // one transaction: select, n bits msb first, deselect
  task automatic frame(input int n, input logic [63:0] tx,
                       output logic [63:0] rx);
    rx = '0;
    @(negedge clk);
    select_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      // opcode then bank and address, msb first
      // callers keep address bits 13:12 at zero
      serial_in <= tx[i];
      idle(HALF);
      // sample the device line just before the rising edge
      rx[i] = line;
      link_clk <= 1'b1;
      idle(HALF);
      link_clk <= 1'b0;
    end
    idle(HALF);
    select_n <= 1'b1;
    // released input shows the inverse, never a stale bit
    serial_in <= ~serial_in;
    idle(4 * HALF);
  endtask : frame
endmodule : ssmp_host

// ==== ssmp_pkg.sv ====
// shared constants and types for the serial slave memory port
package ssmp_pkg;
  // opcodes
  localparam logic [7:0] OP_WORD_READ = 8'h03;
  localparam logic [7:0] OP_WORD_WRITE = 8'h02;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  // bank selector codes
  localparam logic [1:0] BANK_A = 2'h0;
  localparam logic [1:0] BANK_ITEM = 2'h1;
  localparam logic [1:0] BANK_IDENT = 2'h2;
  localparam logic [1:0] BANK_USER = 2'h3;
  // user bank limits
  localparam logic [13:0] ADDR_WRAP_TOP = 14'h07ff;
  localparam logic [13:0] ADDR_USER_TOP = 14'h0eff;
  localparam logic [13:0] ADDR_ZERO = 14'h0000;
  // highest word of identification and item-code banks
  localparam logic [13:0] ADDR_IDENT_TOP = 14'h000f;
  localparam logic [13:0] ADDR_ITEM_TOP = 14'h001f;
  // frame lengths in link clock rising edges
  localparam logic [4:0] OPCODE_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;
  // error status bit positions
  localparam int ERR_KILLED_BIT = 0;
  localparam int ERR_LOCKED_BIT = 1;
  // reset values
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0] ERR_RESET = 2'h0;
  // transaction phases
  typedef enum logic [2:0] {
    SSMP_IDLE, SSMP_OPCODE, SSMP_ADDR, SSMP_RDATA, SSMP_WDATA,
    SSMP_STATUS, SSMP_SKIP
  } ssmp_state_t;
endpackage : ssmp_pkg

// ==== ssmp_port.sv ====
// serial slave memory port: opcode decode, framing, streaming, errors
`timescale 1ns/1ps
// Summary of operation
// RULE1: three opcodes: read 03, write 02, status 05
// RULE2: unknown opcode ignores whole transaction
// RULE3: select rising mid-opcode abandons transaction
// RULE4: bank two bits then fourteen bit address
// RULE5: host sends zero in address top bits
// RULE6: read data changes on falling link edges
// RULE7: select high ends read, output released
// RULE8: address advances every sixteen clocks
// RULE9: low user addresses wrap 7ff to 000
// RULE10: high user reads stop after eff, zeros
// RULE11: id and item banks stop, then zeros
// RULE12: killed, guarded or bank a reads zero
// RULE13: nonzero access key zeros reads, refuses writes
// RULE14: guarded words read zero within range
// RULE15: write: opcode, address, data words, user only
// RULE16: commit only full sixteen bit words
// RULE17: high user writes end at eff
// RULE18: refused writes record error information
// RULE19: write only permitted words of range
// RULE20: status read shifts sixteen bit word
// RULE21: early select rise aborts, then hold low
// RULE22: completed status read clears error bits
// RULE23: bit1 partly locked, bit0 killed, rest zero
// RULE24: status word read only, cleared at power
// RULE25: read errors zero data and record info
// RULE26: select falling restarts counters
module ssmp_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic select_n,
  input wire logic link_clk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en_n,
  input wire logic killed,
  input wire logic key_set,
  input wire logic [7:0] area_guard,
  input wire logic [7:0] area_lock,
  input wire logic bank_lock,
  output logic [1:0] mem_bank,
  output logic [13:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  output logic [15:0] mem_wdata,
  output logic mem_we
);
  // synchronised pins
  logic [2:0] pins_sync;
  // previous link clock and select
  logic clk_prev_reg;
  logic sel_prev_reg;
  // transaction state
  ssmp_pkg::ssmp_state_t state_reg;
  ssmp_pkg::ssmp_state_t state_next;
  logic is_read_reg;
  // bit counter and shift register
  logic [4:0] bit_cnt_reg;
  logic [15:0] shift_reg;
  // address state
  logic [1:0] bank_reg;
  logic [13:0] addr_reg;
  logic high_start_reg;
  logic past_end_reg;
  // output shifter and enable
  logic [15:0] out_reg;
  logic out_en_reg;
  logic status_done_reg;
  // error status bits: [1] partly locked, [0] killed
  logic [1:0] err_reg;
  // memory write strobe and data
  logic we_reg;
  logic [15:0] wdata_reg;
  // guard answers
  logic rd_ok;
  logic wr_ok;
  logic wr_locked;

  ssmp_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pins({select_n, link_clk, serial_in}),
    .pins_sync(pins_sync)
  );

  ssmp_guard u_guard (
    .bank(bank_reg),
    .addr(addr_reg),
    .killed(killed),
    .key_set(key_set),
    .area_guard(area_guard),
    .area_lock(area_lock),
    .bank_lock(bank_lock),
    .past_end(past_end_reg),
    .rd_ok(rd_ok),
    .wr_ok(wr_ok),
    .wr_locked(wr_locked)
  );

  // named decode of synchronised pins and edges
  wire sel_n_s = pins_sync[2];
  wire sck_s = pins_sync[1];
  wire din_s = pins_sync[0];
  wire sck_rise = sck_s && !clk_prev_reg;
  wire sck_fall = !sck_s && clk_prev_reg;
  wire sel_fall = !sel_n_s && sel_prev_reg;
  wire active = !sel_n_s;
  wire [15:0] shift_in = {shift_reg[14:0], din_s};
  wire word_done = sck_rise && (bit_cnt_reg == ssmp_pkg::WORD_BITS - 5'h1);
  wire op_done = sck_rise &&
                 (bit_cnt_reg == ssmp_pkg::OPCODE_BITS - 5'h1);
  wire [7:0] opcode = shift_in[7:0];
  wire [13:0] new_addr = shift_in[13:0];
  wire [1:0] new_bank = shift_in[15:14];

  // last word of the bank the transfer runs in
  function automatic logic [13:0] bank_top(input logic [1:0] b,
                                           input logic high);
    if (b == ssmp_pkg::BANK_IDENT) bank_top = ssmp_pkg::ADDR_IDENT_TOP;
    else if (b == ssmp_pkg::BANK_ITEM) bank_top = ssmp_pkg::ADDR_ITEM_TOP;
    else if (high) bank_top = ssmp_pkg::ADDR_USER_TOP;
    else bank_top = ssmp_pkg::ADDR_WRAP_TOP;
  endfunction : bank_top

  // wrap is only for low user starts; others stop at the top
  wire at_top = addr_reg == bank_top(bank_reg, high_start_reg);
  wire wraps = (bank_reg == ssmp_pkg::BANK_USER) && !high_start_reg;
  wire [13:0] addr_inc = (at_top && wraps) ? ssmp_pkg::ADDR_ZERO :
                         addr_reg + 14'h0001;
  wire stop_now = at_top && !wraps;
  // word that the read shifter loads
  wire [15:0] read_word = rd_ok ? mem_rdata : ssmp_pkg::WORD_RESET;
  wire [15:0] status_word = {14'h0000, err_reg};

  // phase sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ssmp_pkg::SSMP_IDLE: begin
        if (active) state_next = ssmp_pkg::SSMP_OPCODE;
      end
      ssmp_pkg::SSMP_OPCODE: begin
        // RULE1 opcode decode
        if (op_done) begin
          if (opcode == ssmp_pkg::OP_WORD_READ ||
              opcode == ssmp_pkg::OP_WORD_WRITE)
            state_next = ssmp_pkg::SSMP_ADDR;
          else if (opcode == ssmp_pkg::OP_STATUS_READ)
            state_next = ssmp_pkg::SSMP_STATUS;
          // RULE2 unknown ignored
          else
            state_next = ssmp_pkg::SSMP_SKIP;
        end
      end
      ssmp_pkg::SSMP_ADDR: begin
        // RULE4 address framing
        if (word_done)
          state_next = is_read_reg ? ssmp_pkg::SSMP_RDATA :
                       ssmp_pkg::SSMP_WDATA;
      end
      ssmp_pkg::SSMP_RDATA, ssmp_pkg::SSMP_WDATA,
      ssmp_pkg::SSMP_STATUS, ssmp_pkg::SSMP_SKIP: begin
        state_next = state_reg;
      end
      default: state_next = ssmp_pkg::SSMP_IDLE;
    endcase
    // RULE3 RULE7 select rise ends any phase
    if (!active) state_next = ssmp_pkg::SSMP_IDLE;
    // RULE26 restart on select fall
    if (sel_fall) state_next = ssmp_pkg::SSMP_OPCODE;
  end
  skip_quiet_a: assert property ( // RULE2
    @(posedge clk) disable iff (!rst_n) state_reg == ssmp_pkg::SSMP_SKIP
    |-> serial_out_en_n && !mem_we) else $error("unknown opcode acted");
  select_idle_a: assert property ( // RULE3
    @(posedge clk) disable iff (!rst_n) !active |=>
    state_reg == ssmp_pkg::SSMP_IDLE) else $error("select high not idle");

  // edge detect history and state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_reg <= 1'b0;
      sel_prev_reg <= 1'b1;
      state_reg <= ssmp_pkg::SSMP_IDLE;
    end else begin
      clk_prev_reg <= sck_s;
      sel_prev_reg <= sel_n_s;
      state_reg <= state_next;
    end
  end

  // bit counter: opcode then 16-bit frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= ssmp_pkg::WORD_RESET;
    end else if (sel_fall || !active) begin
      // RULE26 fresh counters
      bit_cnt_reg <= 5'h00;
      shift_reg <= ssmp_pkg::WORD_RESET;
    end else if (sck_rise) begin
      shift_reg <= shift_in;
      // opcode end and word end both restart the count
      if (op_done && state_reg == ssmp_pkg::SSMP_OPCODE)
        bit_cnt_reg <= 5'h00;
      else if (word_done)
        bit_cnt_reg <= 5'h00;
      else
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // opcode bit0 marks a read, used when the address phase ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) is_read_reg <= 1'b0;
    else if (op_done && state_reg == ssmp_pkg::SSMP_OPCODE)
      is_read_reg <= opcode[0];
  end

  // address capture and increment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_reg <= 2'h0;
      addr_reg <= ssmp_pkg::ADDR_ZERO;
      high_start_reg <= 1'b0;
      past_end_reg <= 1'b0;
    end else if (state_reg == ssmp_pkg::SSMP_ADDR && word_done) begin
      bank_reg <= new_bank;
      addr_reg <= new_addr;
      high_start_reg <= new_addr > ssmp_pkg::ADDR_WRAP_TOP;
      past_end_reg <= 1'b0;
    end else if (word_done && (state_reg == ssmp_pkg::SSMP_RDATA ||
                               state_reg == ssmp_pkg::SSMP_WDATA)) begin
      // RULE8 RULE9 advance, wrap low user range
      if (stop_now)
        // RULE10 RULE11 RULE17 no wrap: zeros or ignored after top
        past_end_reg <= 1'b1;
      else
        addr_reg <= addr_inc;
    end
  end

  // read and status output shifter, status word loaded on the last opcode rise, otherwise changes on falling edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= ssmp_pkg::WORD_RESET;
      out_en_reg <= 1'b0;
    end else if (!active) begin
      // RULE7 RULE21 release output
      out_reg <= ssmp_pkg::WORD_RESET;
      out_en_reg <= 1'b0;
    end else if (state_reg == ssmp_pkg::SSMP_ADDR && word_done &&
                 is_read_reg) begin
      out_en_reg <= 1'b1;
    end else if (state_reg == ssmp_pkg::SSMP_OPCODE && op_done &&
                 opcode == ssmp_pkg::OP_STATUS_READ) begin
      // RULE20 RULE23 status word, top bits zero
      out_reg <= status_word;
      out_en_reg <= 1'b1;
    end else if (sck_fall && bit_cnt_reg == 5'h00 &&
                 state_reg == ssmp_pkg::SSMP_RDATA) begin
      // RULE6 RULE12 RULE13 RULE14 new word, zeroed if refused
      out_reg <= read_word;
    end else if (sck_fall && !(state_reg == ssmp_pkg::SSMP_STATUS &&
                 bit_cnt_reg == 5'h00 && !status_done_reg)) begin
      // RULE21 first fall keeps the status msb; zeros follow the word
      out_reg <= {out_reg[14:0], 1'b0};
    end
  end
  out_release_a: assert property ( // RULE7
    @(posedge clk) disable iff (!rst_n) !active |=> serial_out_en_n)
    else $error("output driven after select rose");

  // status read completes after sixteen rising edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) status_done_reg <= 1'b0;
    else if (!active) status_done_reg <= 1'b0;
    else if (state_reg == ssmp_pkg::SSMP_STATUS && word_done)
      status_done_reg <= 1'b1;
  end
  wire status_clear = state_reg == ssmp_pkg::SSMP_STATUS && word_done &&
                      !status_done_reg;

  // write commit of complete words only
  wire commit_try = state_reg == ssmp_pkg::SSMP_WDATA && word_done &&
                    !past_end_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      we_reg <= 1'b0;
      wdata_reg <= ssmp_pkg::WORD_RESET;
    end else begin
      // RULE15 RULE16 RULE19 full permitted words only
      we_reg <= commit_try && wr_ok;
      if (commit_try) wdata_reg <= shift_in;
    end
  end
  refused_write_a: assert property ( // RULE18
    @(posedge clk) disable iff (!rst_n) commit_try && (killed || key_set)
    |=> !mem_we) else $error("refused word was written");
  user_write_a: assert property ( // RULE15
    @(posedge clk) disable iff (!rst_n) mem_we |->
    mem_bank == ssmp_pkg::BANK_USER) else $error("write outside user bank");
  // error bits: events win over the status clear
  wire read_try = state_reg == ssmp_pkg::SSMP_RDATA && word_done;
  wire access_try = commit_try || read_try;
  wire set_kill = access_try && killed;
  wire set_lock = (commit_try && wr_locked) ||
                  (read_try && !rd_ok && !killed && !past_end_reg);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // RULE24 cleared at power up, no write path
      err_reg <= ssmp_pkg::ERR_RESET;
    end else begin
      // RULE18 RULE25 record, RULE22 clear after status read
      err_reg[ssmp_pkg::ERR_KILLED_BIT] <= set_kill ||
        (err_reg[ssmp_pkg::ERR_KILLED_BIT] && !status_clear);
      err_reg[ssmp_pkg::ERR_LOCKED_BIT] <= set_lock ||
        (err_reg[ssmp_pkg::ERR_LOCKED_BIT] && !status_clear);
    end
  end
  status_clear_a: assert property ( // RULE22
    @(posedge clk) disable iff (!rst_n) status_clear && !set_kill &&
    !set_lock |=> err_reg == ssmp_pkg::ERR_RESET) else $error("errors kept");
  // write address is held one cycle with the strobe
  logic [13:0] waddr_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) waddr_reg <= ssmp_pkg::ADDR_ZERO;
    else if (commit_try) waddr_reg <= addr_reg;
  end

  assign mem_bank = bank_reg;
  assign mem_addr = we_reg ? waddr_reg : addr_reg;
  assign mem_wdata = wdata_reg;
  assign mem_we = we_reg;
  assign serial_out = out_reg[15];
  assign serial_out_en_n = !out_en_reg;
endmodule : ssmp_port

// ==== ssmp_port_bench.sv ====
// self-checking bench for the serial slave memory port
`timescale 1ns/1ps
module ssmp_port_bench;
  logic clk, rst_n, select_n, link_clk, serial_in, serial_out;
  logic serial_out_en_n, killed, key_set, bank_lock, mem_we, en_seen;
  logic [7:0] area_guard, area_lock;
  logic [1:0] mem_bank;
  logic [13:0] mem_addr;
  logic [15:0] mem_rdata, mem_wdata;
  logic [31:0] wlog [$]; // bank, address, data of each write pulse
  logic [63:0] rx;
  int mismatches, samples_checked;
  wire line; // device pin level as the host sees it
  // memory contents: a pattern that differs per bank and address
  function automatic logic [15:0] fill(input logic [1:0] b,
                                       input logic [13:0] a);
    return {b, a} ^ 16'h3c3c;
  endfunction : fill
  assign mem_rdata = fill(mem_bank, mem_addr);
  assign line = serial_out_en_n ? 1'bz : serial_out;
  ssmp_port u_dut (.clk, .rst_n, .select_n, .link_clk, .serial_in,
    .serial_out, .serial_out_en_n, .killed, .key_set, .area_guard,
    .area_lock, .bank_lock, .mem_bank, .mem_addr, .mem_rdata,
    .mem_wdata, .mem_we);
  ssmp_host u_host (.clk, .select_n, .link_clk, .serial_in, .line);
  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // log writes mid-cycle, away from the edge that launches the strobe
  always @(negedge clk) begin
    if (mem_we === 1'b1) wlog.push_back({mem_bank, mem_addr, mem_wdata});
    if (serial_out_en_n === 1'b0) en_seen <= 1'b1;
  end
  task automatic check(input string what, input logic [31:0] exp, act);
    samples_checked++;
    if (act !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, act);
    end
  endtask : check
  // full status read with eight extra clocks of hold
  task automatic status(input logic [15:0] exp);
    u_host.frame(32, {8'h05, 24'hffffff}, rx);
    check("status", exp, rx[23:8]);
    check("hold low", 0, rx[7:0]);
  endtask : status
  task automatic t_read_wrap();
    u_host.frame(56, {8'h03, 2'h3, 14'h07ff, 32'hffffffff}, rx);
    check("word 7ff", fill(2'h3, 14'h07ff), rx[31:16]);
    check("word 000", fill(2'h3, 14'h0000), rx[15:0]);
    check("released", 1, serial_out_en_n);
    $display("test read_wrap done");
  endtask : t_read_wrap
  task automatic t_read_stop();
    logic [1:0] b [3] = '{2'h3, 2'h2, 2'h1};
    logic [13:0] a [3] = '{14'h0eff, 14'h000f, 14'h001f};
    for (int i = 0; i < 3; i++) begin
      u_host.frame(56, {8'h03, b[i], a[i], 32'h0}, rx);
      check("top word", fill(b[i], a[i]), rx[31:16]);
      check("past top", 0, rx[15:0]);
    end
    u_host.frame(40, {8'h03, 2'h0, 14'h0004, 16'h0}, rx);
    check("bank a", 0, rx[15:0]);
    $display("test read_stop done");
  endtask : t_read_stop
  task automatic t_read_guard();
    status(16'h0002);
    area_guard = 8'h02;
    u_host.frame(56, {8'h03, 2'h3, 14'h01ff, 32'h0}, rx);
    check("open word", fill(2'h3, 14'h01ff), rx[31:16]);
    check("guarded", 0, rx[15:0]);
    area_guard = 8'h00;
    key_set = 1'b1;
    u_host.frame(40, {8'h03, 2'h3, 14'h0010, 16'h0}, rx);
    check("keyed", 0, rx[15:0]);
    key_set = 1'b0;
    status(16'h0002);
    killed = 1'b1;
    u_host.frame(40, {8'h03, 2'h3, 14'h0010, 16'h0}, rx);
    check("killed", 0, rx[15:0]);
    killed = 1'b0;
    u_host.frame(12, {8'h05, 4'h0}, rx);
    check("aborted", 1, serial_out_en_n);
    status(16'h0001);
    status(16'h0000);
    $display("test read_guard done");
  endtask : t_read_guard
  task automatic t_write();
    wlog.delete();
    u_host.frame(64, {8'h02, 2'h3, 14'h07ff, 32'h1234abcd, 8'h55},
      rx);
    check("write count", 2, wlog.size());
    check("write 7ff", {2'h3, 14'h07ff, 16'h1234}, wlog[0]);
    check("write 000", {2'h3, 14'h0000, 16'habcd}, wlog[1]);
    wlog.delete();
    u_host.frame(56, {8'h02, 2'h3, 14'h0eff, 32'h9876fedc}, rx);
    check("top count", 1, wlog.size());
    check("write eff", {2'h3, 14'h0eff, 16'h9876}, wlog[0]);
    wlog.delete();
    area_lock = 8'h01;
    u_host.frame(56, {8'h02, 2'h3, 14'h01ff, 32'h11112222}, rx);
    area_lock = 8'h00;
    check("part count", 1, wlog.size());
    check("write 200", {2'h3, 14'h0200, 16'h2222}, wlog[0]);
    status(16'h0002);
    for (int i = 0; i < 5; i++) begin
      wlog.delete();
      killed = (i == 0);
      key_set = (i == 1);
      bank_lock = (i == 2);
      u_host.frame(40, {8'h02, (i == 3) ? 2'h2 : 2'h3,
        (i == 4) ? 14'h0f00 : 14'h0010, 16'h5555}, rx);
      killed = 1'b0;
      key_set = 1'b0;
      bank_lock = 1'b0;
      check("refused", 0, wlog.size());
      status((i == 0) ? 16'h0001 : 16'h0002);
    end
    $display("test write done");
  endtask : t_write
  task automatic t_opcode();
    logic [7:0] op [2] = '{8'h04, 8'h83};
    wlog.delete();
    for (int i = 0; i < 2; i++) begin
      en_seen = 1'b0;
      u_host.frame(40, {op[i], 2'h3, 14'h0010, 16'h7777}, rx);
      check("no drive", 0, en_seen);
    end
    u_host.frame(5, 64'h0, rx);
    u_host.frame(40, {8'h02, 2'h3, 14'h0020, 16'h4242}, rx);
    check("one write", 1, wlog.size());
    check("fresh write", {2'h3, 14'h0020, 16'h4242}, wlog[0]);
    status(16'h0000);
    $display("test opcode done");
  endtask : t_opcode
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // watchdog sized well past the expected run of about 215 us
  initial begin
    #400us;
    mismatches++;
    $display("watchdog expired");
    conclude();
  end
  // reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    {killed, key_set, bank_lock, en_seen} = 4'h0;
    area_guard = 8'h00;
    area_lock = 8'h00;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_read_wrap();
    t_read_stop();
    t_read_guard();
    t_write();
    t_opcode();
    conclude();
  end
endmodule : ssmp_port_bench

// ==== ssmp_sync.sv ====
// two-flop synchroniser for a bundle of link pins
`timescale 1ns/1ps
module ssmp_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] pins,
  output logic [2:0] pins_sync
);
  // first stage is read only by the second stage
  logic [2:0] meta_reg;

  // sampled from outside the clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 3'h5;
      pins_sync <= 3'h5;
    end else begin
      meta_reg <= pins;
      pins_sync <= meta_reg;
    end
  end
endmodule : ssmp_sync
